// ### rtl/tpa_pkg.sv
package tpa_pkg;

	// Clock of both ends and the link clock that the host derives from it.
	localparam int CLOCK_PERIOD_NS  = 4;
	localparam int LINK_PERIOD_NS   = 48;
	localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLOCK_PERIOD_NS);
	// Half period, in clock cycles, of the half-rate reference clock the host makes.
	localparam int REF_HALF_CYCLES  = 2;

	// Character layout: eight data bits, two type-control bits.
	localparam int CHAR_W = 8;
	localparam int CTL_W  = 2;
	localparam int SLOT_W = CHAR_W + CTL_W;

	// Phase-align buffer geometry; each entry holds two characters.
	// The write side sees the read pointer two write clocks late, so the depth leaves
	// room for the centre fill plus that lag without a false full.
	localparam int                BUF_DEPTH = 8;
	localparam int                PTR_W     = $clog2(BUF_DEPTH) + 1;
	localparam logic [PTR_W-1:0] BUF_FULL  = PTR_W'(BUF_DEPTH);
	localparam logic [PTR_W-1:0] CENTRE    = PTR_W'(BUF_DEPTH / 4);

	// Phase reset: least rising reference edges low, and the host hold time.
	localparam int PR_MIN_EDGES   = 2;
	localparam int PR_HOLD_CYCLES = (PR_MIN_EDGES + 2) * 2 * REF_HALF_CYCLES;
	// Default wait for the transmit PLL to lock before the first phase reset.
	localparam int PLL_LOCK_TIME_CYCLES = 64;

	// Encoding mode that bypasses the encoder.
	localparam logic [1:0] TPA_MODE_BYPASS = 2'h0;

	typedef enum logic [1:0] {
		TPA_CKSEL_REF    = 2'h0,
		TPA_CKSEL_OWN    = 2'h1,
		TPA_CKSEL_CHAN_A = 2'h2
	} tpa_cksel_t;

	typedef enum logic [2:0] {
		TPA_ST_LOCK = 3'h1,
		TPA_ST_PRST = 3'h2,
		TPA_ST_RUN  = 3'h4
	} tpa_host_st_t;

	function automatic logic [PTR_W-1:0] tpa_bin2gray(input logic [PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PTR_W-1:0] tpa_gray2bin(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b[PTR_W-1] = g[PTR_W-1];
		for (int i = PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

endpackage

// ### rtl/tpa_link_if.sv
`timescale 1ns/1ns
interface tpa_link_if;
	logic                         chan_a_input_clock;
	logic                         chan_b_input_clock;
	logic                         reference_clock;
	logic [tpa_pkg::CHAR_W-1:0]   char_in_chan_a;
	logic [tpa_pkg::CHAR_W-1:0]   char_in_chan_b;
	logic [tpa_pkg::CTL_W-1:0]    chan_char_type_ctl_a;
	logic [tpa_pkg::CTL_W-1:0]    chan_char_type_ctl_b;
	logic                         phase_align_reset_n;
	logic [1:0]                   input_clock_source_sel;
	logic                         ref_half_rate_sel;
	logic [1:0]                   encode_mode_sel;
	logic                         chan_tx_error_flag_a;
	logic                         chan_tx_error_flag_b;

	modport device (
		input  chan_a_input_clock,
		input  chan_b_input_clock,
		input  reference_clock,
		input  char_in_chan_a,
		input  char_in_chan_b,
		input  chan_char_type_ctl_a,
		input  chan_char_type_ctl_b,
		input  phase_align_reset_n,
		input  input_clock_source_sel,
		input  ref_half_rate_sel,
		input  encode_mode_sel,
		output chan_tx_error_flag_a,
		output chan_tx_error_flag_b
	);

	modport host (
		output chan_a_input_clock,
		output chan_b_input_clock,
		output reference_clock,
		output char_in_chan_a,
		output char_in_chan_b,
		output chan_char_type_ctl_a,
		output chan_char_type_ctl_b,
		output phase_align_reset_n,
		output input_clock_source_sel,
		output ref_half_rate_sel,
		output encode_mode_sel,
		input  chan_tx_error_flag_a,
		input  chan_tx_error_flag_b
	);
endinterface // tpa_link_if

// ### rtl/tpa_device.sv
`timescale 1ns/1ns
module tpa_device #(
	parameter int CHAR_DIV = 1
) (
	// Character-rate clock and reset.
	input  wire logic                            clock,
	input  wire logic                            sys_rst,
	// Link to the host transmit logic.
	tpa_link_if.device                           link,
	// Word-sync sequence sent on a channel, one pulse each.
	input  wire logic [1:0]                      word_sync_sent,
	// Characters toward the encoder or the shifter.
	output logic      [1:0][tpa_pkg::SLOT_W-1:0] tx_char,
	output logic      [1:0]                      tx_char_valid,
	output logic                                 tx_char_raw
);
	import tpa_pkg::*;

	logic                  bypass;
	logic [1:0]            wclk;
	logic [1:0][SLOT_W-1:0] pin_char;
	logic [1:0]            err;
	logic [7:0]            div_q;
	logic                  char_stb;
	logic                  raw_q;
	logic                  half_rate;

	// Static straps; the buffer is unused with the full-rate reference.
	assign half_rate = link.ref_half_rate_sel;
	assign bypass    = (link.input_clock_source_sel == TPA_CKSEL_REF) && !half_rate;

	// Clock of each input register; the select is static, so the mux never switches live.
	assign wclk[0] = (link.input_clock_source_sel == TPA_CKSEL_REF) ? link.reference_clock :
	                 link.chan_a_input_clock;
	assign wclk[1] = (link.input_clock_source_sel == TPA_CKSEL_REF)    ? link.reference_clock :
	                 (link.input_clock_source_sel == TPA_CKSEL_CHAN_A) ? link.chan_a_input_clock :
	                 link.chan_b_input_clock;

	// Type controls sit above the eight character bits.
	assign pin_char[0] = {link.chan_char_type_ctl_a, link.char_in_chan_a};
	assign pin_char[1] = {link.chan_char_type_ctl_b, link.char_in_chan_b};

	// One character slot every CHAR_DIV cycles on the read side.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			div_q <= 8'h00;
		end else if (div_q == 8'(CHAR_DIV - 1)) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end
	assign char_stb = (div_q == 8'h00);

	// Flags the outgoing characters as raw ten-bit words or as encoder input.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			raw_q <= 1'b0;
		end else begin
			raw_q <= (link.encode_mode_sel == TPA_MODE_BYPASS);
		end
	end
	assign tx_char_raw = raw_q;

	assign link.chan_tx_error_flag_a = err[0];
	assign link.chan_tx_error_flag_b = err[1];

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		// Write side, on the selected input clock.
		logic [SLOT_W-1:0]   rise_q;
		logic [SLOT_W-1:0]   fall_q;
		logic [PTR_W-1:0]    wp_q;
		logic [PTR_W-1:0]    wg_q;
		logic [PTR_W-1:0]    rg_s1_q;
		logic [PTR_W-1:0]    rg_s2_q;
		logic [PTR_W-1:0]    w_fill;
		logic                full;
		logic                ovf_tgl_q;
		logic [2*SLOT_W-1:0] mem_q [BUF_DEPTH];
		// Read side, on the character-rate clock.
		logic [PTR_W-1:0]    wg_s1_q;
		logic [PTR_W-1:0]    wg_s2_q;
		logic [2:0]          ovf_s_q;
		logic [1:0]          prst_s_q;
		logic [PTR_W-1:0]    rp_q;
		logic [PTR_W-1:0]    rg_q;
		logic [PTR_W-1:0]    wp_r;
		logic                half_q;
		logic                empty;
		logic                pr_low;
		logic                pr_active;
		logic                uflow;
		logic [2*SLOT_W-1:0] slot;
		logic [SLOT_W-1:0]   char_q;
		logic                valid_q;
		logic                err_q;

		always_ff @(posedge wclk[ch] or posedge sys_rst) begin
			if (sys_rst) begin
				rise_q <= '0;
			end else begin
				rise_q <= pin_char[ch];
			end
		end

		// The falling-edge register only matters with the half-rate reference.
		always_ff @(negedge wclk[ch] or posedge sys_rst) begin
			if (sys_rst) begin
				fall_q <= '0;
			end else begin
				fall_q <= pin_char[ch];
			end
		end

		always_ff @(posedge wclk[ch] or posedge sys_rst) begin
			if (sys_rst) begin
				rg_s1_q <= '0;
				rg_s2_q <= '0;
			end else begin
				rg_s1_q <= rg_q;
				rg_s2_q <= rg_s1_q;
			end
		end

		assign w_fill = wp_q - tpa_gray2bin(rg_s2_q);
		assign full   = (w_fill >= BUF_FULL);

		always_ff @(posedge wclk[ch] or posedge sys_rst) begin
			if (sys_rst) begin
				wp_q      <= '0;
				wg_q      <= '0;
				ovf_tgl_q <= 1'b0;
			end else if (!bypass) begin
				if (full) begin
					ovf_tgl_q <= ~ovf_tgl_q;
				end else begin
					wp_q <= wp_q + PTR_W'(1);
					wg_q <= tpa_bin2gray(wp_q + PTR_W'(1));
				end
			end
		end

		// Earlier character in the low half, the falling-edge one above it.
		always_ff @(posedge wclk[ch]) begin
			if (!bypass && !full) begin
				mem_q[wp_q[PTR_W-2:0]] <= {fall_q, rise_q};
			end
		end

		always_ff @(posedge clock or posedge sys_rst) begin
			if (sys_rst) begin
				wg_s1_q  <= '0;
				wg_s2_q  <= '0;
				ovf_s_q  <= 3'h0;
				prst_s_q <= 2'h0;
			end else begin
				wg_s1_q  <= wg_q;
				wg_s2_q  <= wg_s1_q;
				ovf_s_q  <= {ovf_s_q[1:0], ovf_tgl_q};
				prst_s_q <= {prst_s_q[0], link.phase_align_reset_n};
			end
		end

		assign wp_r      = tpa_gray2bin(wg_s2_q);
		assign empty     = (wp_r == rp_q);
		assign slot      = mem_q[rp_q[PTR_W-2:0]];
		assign pr_low    = !prst_s_q[1] && !bypass;
		assign pr_active = pr_low;
		assign uflow     = !bypass && !pr_active && char_stb && !half_q && empty;

		always_ff @(posedge clock or posedge sys_rst) begin
			if (sys_rst) begin
				rp_q    <= '0;
				rg_q    <= '0;
				half_q  <= 1'b0;
				char_q  <= '0;
				valid_q <= 1'b0;
			end else if (bypass) begin
				char_q  <= pin_char[ch];
				valid_q <= 1'b1;
			end else if (pr_active) begin
				// Characters stop while the read pointer is pulled CENTRE entries, a quarter of the buffer, behind the write pointer.
				rp_q    <= wp_r - CENTRE;
				rg_q    <= tpa_bin2gray(wp_r - CENTRE);
				half_q  <= 1'b0;
				valid_q <= 1'b0;
			end else if (char_stb && half_q) begin
				char_q  <= slot[2*SLOT_W-1:SLOT_W];
				valid_q <= 1'b1;
				half_q  <= 1'b0;
				rp_q    <= rp_q + PTR_W'(1);
				rg_q    <= tpa_bin2gray(rp_q + PTR_W'(1));
			end else if (char_stb && !empty) begin
				char_q  <= slot[SLOT_W-1:0];
				valid_q <= 1'b1;
				if (half_rate) begin
					half_q <= 1'b1;
				end else begin
					rp_q <= rp_q + PTR_W'(1);
					rg_q <= tpa_bin2gray(rp_q + PTR_W'(1));
				end
			end else begin
				valid_q <= 1'b0;
			end
		end

		// A fault arriving with a clear still sets the flag.
		always_ff @(posedge clock or posedge sys_rst) begin
			if (sys_rst) begin
				err_q <= 1'b0;
			end else if (uflow || (ovf_s_q[2] != ovf_s_q[1])) begin
				err_q <= 1'b1;
			end else if (word_sync_sent[ch] || pr_low) begin
				err_q <= 1'b0;
			end
		end

		assign tx_char[ch]       = char_q;
		assign tx_char_valid[ch] = valid_q;
		assign err[ch]           = err_q;
	end

endmodule // tpa_device

// ### rtl/tpa_host.sv
`timescale 1ns/1ns
module tpa_host #(
	parameter int LINK_HALF = tpa_pkg::LINK_HALF_CYCLES,
	parameter int REF_HALF  = tpa_pkg::REF_HALF_CYCLES,
	parameter int LOCK_WAIT = tpa_pkg::PLL_LOCK_TIME_CYCLES
) (
	// Clock and reset.
	input  wire logic                         clock,
	input  wire logic                         sys_rst,
	// Link toward the transceiver.
	tpa_link_if.host                          link,
	// Static configuration.
	input  wire logic [1:0]                   cfg_clock_source,
	input  wire logic                         cfg_half_rate,
	input  wire logic [1:0]                   cfg_encode_mode,
	// Characters to send.
	input  wire logic [tpa_pkg::CHAR_W-1:0]   char_a,
	input  wire logic [tpa_pkg::CTL_W-1:0]    ctl_a,
	input  wire logic [tpa_pkg::CHAR_W-1:0]   char_b,
	input  wire logic [tpa_pkg::CTL_W-1:0]    ctl_b,
	output logic                              char_take,
	// Phase reset request and status.
	input  wire logic                         phase_reset_req,
	output logic                              link_ready,
	output logic      [1:0]                   tx_error
);
	import tpa_pkg::*;

	tpa_host_st_t        st_q;
	logic [15:0]         cnt_q;
	logic [7:0]          lk_cnt_q;
	logic [7:0]          rf_cnt_q;
	logic                lclk_q;
	logic                rclk_q;
	logic [1:0]          cksel_q;
	logic                rate_q;
	logic [1:0]          mode_q;
	logic [SLOT_W-1:0]   da_q;
	logic [SLOT_W-1:0]   db_q;
	logic                take_q;
	logic                prst_n_q;
	logic                ready_q;
	logic [1:0]          err_q;
	logic                upd;
	logic                buf_used;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cksel_q <= 2'h0;
			rate_q  <= 1'b0;
			mode_q  <= 2'h0;
			err_q   <= 2'h0;
		end else begin
			cksel_q <= cfg_clock_source;
			rate_q  <= cfg_half_rate;
			mode_q  <= cfg_encode_mode;
			err_q   <= {link.chan_tx_error_flag_b, link.chan_tx_error_flag_a};
		end
	end

	// Interface and half-rate reference clocks, divided from the own clock.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			lk_cnt_q <= 8'h00;
			lclk_q   <= 1'b0;
		end else if (lk_cnt_q == 8'(LINK_HALF - 1)) begin
			lk_cnt_q <= 8'h00;
			lclk_q   <= ~lclk_q;
		end else begin
			lk_cnt_q <= lk_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rf_cnt_q <= 8'h00;
			rclk_q   <= 1'b0;
		end else if (rf_cnt_q == 8'(REF_HALF - 1)) begin
			rf_cnt_q <= 8'h00;
			rclk_q   <= ~rclk_q;
		end else begin
			rf_cnt_q <= rf_cnt_q + 8'h01;
		end
	end

	// Data changes midway between the edges on which the device samples it; with the full-rate reference it changes every clock.
	always_comb begin
		if (cksel_q == TPA_CKSEL_REF) begin
			upd = rate_q ? (rf_cnt_q == 8'(REF_HALF / 2 - 1)) : 1'b1;
		end else begin
			upd = (lk_cnt_q == 8'(LINK_HALF - 1)) && lclk_q;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			da_q   <= '0;
			db_q   <= '0;
			take_q <= 1'b0;
		end else begin
			take_q <= upd;
			if (upd) begin
				da_q <= {ctl_a, char_a};
				db_q <= {ctl_b, char_b};
			end
		end
	end

	assign buf_used = !((cksel_q == TPA_CKSEL_REF) && !rate_q);

	// Lock wait, then phase reset while the buffer is in use, then normal run.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_q     <= TPA_ST_LOCK;
			cnt_q    <= 16'h0000;
			prst_n_q <= 1'b1;
			ready_q  <= 1'b0;
		end else begin
			unique case (st_q)
				TPA_ST_LOCK: begin
					if (cnt_q == 16'(LOCK_WAIT - 1)) begin
						cnt_q <= 16'h0000;
						if (buf_used) begin
							st_q     <= TPA_ST_PRST;
							prst_n_q <= 1'b0;
						end else begin
							st_q    <= TPA_ST_RUN;
							ready_q <= 1'b1;
						end
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				TPA_ST_PRST: begin
					if (cnt_q == 16'(PR_HOLD_CYCLES - 1)) begin
						cnt_q    <= 16'h0000;
						st_q     <= TPA_ST_RUN;
						prst_n_q <= 1'b1;
						ready_q  <= 1'b1;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
				TPA_ST_RUN: begin
					if (phase_reset_req && buf_used) begin
						st_q     <= TPA_ST_PRST;
						prst_n_q <= 1'b0;
						ready_q  <= 1'b0;
					end
				end
			endcase
		end
	end

	assign link.chan_a_input_clock     = lclk_q;
	assign link.chan_b_input_clock     = lclk_q;
	assign link.reference_clock        = rclk_q;
	assign link.char_in_chan_a         = da_q[CHAR_W-1:0];
	assign link.chan_char_type_ctl_a   = da_q[SLOT_W-1:CHAR_W];
	assign link.char_in_chan_b         = db_q[CHAR_W-1:0];
	assign link.chan_char_type_ctl_b   = db_q[SLOT_W-1:CHAR_W];
	assign link.phase_align_reset_n    = prst_n_q;
	assign link.input_clock_source_sel = cksel_q;
	assign link.ref_half_rate_sel      = rate_q;
	assign link.encode_mode_sel        = mode_q;
	assign char_take                   = take_q;
	assign link_ready                  = ready_q;
	assign tx_error                    = err_q;

endmodule // tpa_host

// ### verif/tpa_link_sva.sv
`timescale 1ns/1ns
module tpa_link_sva (
	// Clock and reset.
	input wire logic       clock,
	input wire logic       sys_rst,
	// Link signals.
	input wire logic       chan_a_input_clock,
	input wire logic       chan_b_input_clock,
	input wire logic       reference_clock,
	input wire logic [7:0] char_in_chan_a,
	input wire logic [7:0] char_in_chan_b,
	input wire logic [1:0] chan_char_type_ctl_a,
	input wire logic [1:0] chan_char_type_ctl_b,
	input wire logic       phase_align_reset_n,
	input wire logic [1:0] input_clock_source_sel,
	input wire logic       ref_half_rate_sel,
	input wire logic [1:0] encode_mode_sel,
	input wire logic       chan_tx_error_flag_a,
	input wire logic       chan_tx_error_flag_b
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_prst_min_hold: assert property ($fell(phase_align_reset_n) |-> !phase_align_reset_n [*8])
		else $error("phase reset released too early");
	a_prst_release: assert property ($fell(phase_align_reset_n) |-> ##[8:60] phase_align_reset_n)
		else $error("phase reset held too long");
	a_err_clear_a: assert property (!phase_align_reset_n [*5] |-> !chan_tx_error_flag_a)
		else $error("channel a fault not cleared by phase reset");
	a_err_clear_b: assert property (!phase_align_reset_n [*5] |-> !chan_tx_error_flag_b)
		else $error("channel b fault not cleared by phase reset");
	a_sel_legal: assert property (input_clock_source_sel != 2'h3)
		else $error("illegal clock source select");
	a_rate_ref_only: assert property (ref_half_rate_sel |-> input_clock_source_sel == 2'h0)
		else $error("half rate with interface clock select");
	a_rise_data_hold: assert property (ref_half_rate_sel && $rose(reference_clock)
		|-> $stable(char_in_chan_a) && $stable(chan_char_type_ctl_a))
		else $error("data moved at rising reference edge");
	a_fall_data_hold: assert property (ref_half_rate_sel && $fell(reference_clock)
		|-> $stable(char_in_chan_b) && $stable(chan_char_type_ctl_b))
		else $error("data moved at falling reference edge");
	a_clocks_paired: assert property (chan_a_input_clock == chan_b_input_clock)
		else $error("interface clocks differ");
endmodule // tpa_link_sva

// ### verif/tb_tx_input_phase_align.sv
`timescale 1ns/1ns
module tb_tx_input_phase_align;
	import tpa_pkg::*;
	localparam int         NP       = 4;
	localparam int         DIV_T[NP]  = '{12, 12, 2, 1};
	localparam logic [1:0] SEL_T[NP]  = '{2'h1, 2'h2, 2'h0, 2'h0};
	localparam logic       RATE_T[NP] = '{1'b0, 1'b0, 1'b1, 1'b0};
	localparam logic [1:0] MODE_T[NP] = '{2'h1, 2'h0, 2'h2, 2'h0};

	logic          clock    = 1'b0;
	logic          sys_rst  = 1'b1;
	logic          prst_req = 1'b0;
	wire  [NP-1:0] ready;
	int            nch[NP]  = '{0, 0, 0, 0};
	int            n_fail   = 0;
	int            checks   = 0;
	logic [1:0]    f_ws     = 2'h0;
	logic [1:0]    f_err;
	logic [1:0]    f_low;

	always #2 clock = ~clock;

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (exp !== got) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask

	// Channel b carries the count scrambled, so swapped channels show up.
	function automatic logic [SLOT_W-1:0] exp_slot(input int ch, input logic [7:0] v);
		logic [7:0] d;
		d = (ch == 1) ? (v ^ 8'h5a) : v;
		return {v[2*ch+1 -: 2], d};
	endfunction

	task automatic end_sim();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic wait_ready();
		int i;
		for (i = 0; i < 600 && ready !== '1; i++) begin
			@(posedge clock);
		end
		if (ready !== '1) begin
			$display("MISMATCH link_ready expected %h seen %h", {NP{1'b1}}, ready);
			n_fail++;
			end_sim();
		end
	endtask

	for (genvar g = 0; g < NP; g++) begin : gp
		tpa_link_if             u_tpa_link_if ();
		logic [7:0]             cnt   = 8'h00;
		logic                   take;
		logic                   rdy;
		logic                   raw;
		logic [1:0]             err;
		logic [1:0]             vld;
		logic [1:0][SLOT_W-1:0] slot;
		logic [1:0]             seen  = 2'h0;
		logic [1:0][7:0]        last;
		int                     quiet = 100;

		tpa_host #(.LOCK_WAIT(4)) u_tpa_host (
			.clock           (clock),
			.sys_rst         (sys_rst),
			.link            (u_tpa_link_if.host),
			.cfg_clock_source(SEL_T[g]),
			.cfg_half_rate   (RATE_T[g]),
			.cfg_encode_mode (MODE_T[g]),
			.char_a          (cnt),
			.ctl_a           (cnt[1:0]),
			.char_b          (cnt ^ 8'h5a),
			.ctl_b           (cnt[3:2]),
			.char_take       (take),
			.phase_reset_req (prst_req),
			.link_ready      (rdy),
			.tx_error        (err)
		);
		tpa_device #(.CHAR_DIV(DIV_T[g])) u_tpa_device (
			.clock         (clock),
			.sys_rst       (sys_rst),
			.link          (u_tpa_link_if.device),
			.word_sync_sent(2'h0),
			.tx_char       (slot),
			.tx_char_valid (vld),
			.tx_char_raw   (raw)
		);
		assign ready[g] = rdy;

		if (g == 2) begin : gc
			tpa_link_sva u_tpa_link_sva (
				.clock                 (clock),
				.sys_rst               (sys_rst),
				.chan_a_input_clock    (u_tpa_link_if.chan_a_input_clock),
				.chan_b_input_clock    (u_tpa_link_if.chan_b_input_clock),
				.reference_clock       (u_tpa_link_if.reference_clock),
				.char_in_chan_a        (u_tpa_link_if.char_in_chan_a),
				.char_in_chan_b        (u_tpa_link_if.char_in_chan_b),
				.chan_char_type_ctl_a  (u_tpa_link_if.chan_char_type_ctl_a),
				.chan_char_type_ctl_b  (u_tpa_link_if.chan_char_type_ctl_b),
				.phase_align_reset_n   (u_tpa_link_if.phase_align_reset_n),
				.input_clock_source_sel(u_tpa_link_if.input_clock_source_sel),
				.ref_half_rate_sel     (u_tpa_link_if.ref_half_rate_sel),
				.encode_mode_sel       (u_tpa_link_if.encode_mode_sel),
				.chan_tx_error_flag_a  (u_tpa_link_if.chan_tx_error_flag_a),
				.chan_tx_error_flag_b  (u_tpa_link_if.chan_tx_error_flag_b)
			);
		end

		// Each accepted character advances the count by one.
		always @(posedge clock) begin
			if (sys_rst) begin
				cnt <= 8'h00;
			end else if (take === 1'b1) begin
				cnt <= cnt + 8'h01;
			end
		end

		// Continuity is not judged while the buffer is being realigned.
		always @(posedge clock) begin
			if (sys_rst || rdy !== 1'b1) begin
				quiet = 100;
			end else if (quiet != 0) begin
				quiet--;
			end
			for (int c = 0; c < 2; c++) begin
				if (vld[c] === 1'b1 && quiet == 0) begin
					nch[g]++;
					if (seen[c]) begin
						cmp("tx_char", 16'(exp_slot(c, last[c] + 8'h01)), 16'(slot[c]));
					end
					cmp("tx_char_raw", 16'(MODE_T[g] == 2'h0), 16'(raw));
					cmp("tx_error", 16'h0, 16'(err));
					last[c] = slot[c][7:0] ^ ((c == 1) ? 8'h5a : 8'h00);
					seen[c] = 1'b1;
				end
			end
			if (quiet != 0) begin
				seen = 2'h0;
			end
		end
	end

	// Reader twice as fast as the writer: the buffer must run dry and flag it.
	tpa_link_if u_tpa_link_if ();
	tpa_host #(.LOCK_WAIT(4)) u_tpa_host (
		.clock           (clock),
		.sys_rst         (sys_rst),
		.link            (u_tpa_link_if.host),
		.cfg_clock_source(2'h1),
		.cfg_half_rate   (1'b0),
		.cfg_encode_mode (2'h1),
		.char_a          (8'h00),
		.ctl_a           (2'h0),
		.char_b          (8'h00),
		.ctl_b           (2'h0),
		.char_take       (),
		.phase_reset_req (1'b0),
		.link_ready      (),
		.tx_error        (f_err)
	);
	tpa_device #(.CHAR_DIV(6)) u_tpa_device (
		.clock         (clock),
		.sys_rst       (sys_rst),
		.link          (u_tpa_link_if.device),
		.word_sync_sent(f_ws),
		.tx_char       (),
		.tx_char_valid (),
		.tx_char_raw   ()
	);

	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		wait_ready();
		repeat (800) @(posedge clock);
		cmp("tx_error_fast", 16'h3, 16'(f_err));
		// Word sync is held two cycles so that one of them misses the read strobe.
		f_ws <= 2'h3;
		repeat (2) @(posedge clock);
		f_ws <= 2'h0;
		#1;
		f_low = ~f_err;
		@(posedge clock);
		#1;
		f_low = f_low | ~f_err;
		cmp("tx_error_cleared", 16'h3, 16'(f_low));
		@(posedge clock);
		prst_req <= 1'b1;
		@(posedge clock);
		prst_req <= 1'b0;
		@(posedge clock);
		#1;
		cmp("link_ready", 16'h8, 16'(ready));
		wait_ready();
		repeat (800) @(posedge clock);
		for (int g = 0; g < NP; g++) begin
			cmp("char_count_low", 16'h1, 16'(nch[g] > 40));
		end
		end_sim();
	end
endmodule // tb_tx_input_phase_align
